// >>> testbench/synth_cal_host.sv
`timescale 1ns/100ps
module synth_cal_host (
  input  wire logic                  sys_clk_i,
  output synth_cal_pkg::reg_access_t access_o
);
  import synth_cal_pkg::*;
  initial access_o = '0;
  // Idle data lines toggle so stale values are never mistaken for writes
  task automatic put(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    access_o = '{w, a, w ? d : ~access_o.wdata};
  endtask
endmodule

// >>> testbench/synth_cal_sva.sv
`timescale 1ns/100ps
module synth_cal_sva (
  input wire logic                       sys_clk_i,
  input wire logic                       rst_i,
  input wire synth_cal_pkg::reg_access_t access_i,
  input wire synth_cal_pkg::cal_result_t cal_result_i,
  input wire logic                       sleep_i,
  input wire logic                       converter_keep_setting_i,
  input wire logic [7:0]                 rdata_o,
  input wire synth_cal_pkg::synth_ctrl_t synth_ctrl_o,
  input wire logic [7:0]                 analog_test_b_int_o,
  input wire logic [7:0]                 analog_test_a_int_o
);
  import synth_cal_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  chk_unmapped_read: assert property (!(access_i.addr inside {[6'h23:6'h26], [6'h29:6'h2e]}) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_pump_write: assert property (access_i.wr_en && access_i.addr == 6'h23 |=>
    synth_ctrl_o.pump_cal_stage_enable == |$past(access_i.wdata[5:4])
    && synth_ctrl_o.pump_current == $past(access_i.wdata[3:0])) else $error("pump fields wrong");
  chk_vco_write: assert property (access_i.wr_en && access_i.addr == 6'h24 |=>
    synth_ctrl_o.vco_high_core_select == $past(access_i.wdata[5])
    && synth_ctrl_o.vco_current == $past(access_i.wdata[4:0])) else $error("vco fields wrong");
  chk_result_load: assert property (cal_result_i.wr_en && !access_i.wr_en |=>
    synth_ctrl_o.coarse_tune == $past(cal_result_i.coarse_tune)
    && synth_ctrl_o.vco_current == $past(cal_result_i.vco_current)) else $error("result not loaded");
  chk_ctrl_write: assert property (access_i.wr_en && access_i.addr == 6'h26 |=>
    synth_ctrl_o.cal_control == $past(access_i.wdata[6:0])) else $error("control field wrong");
  chk_sel_cal: assert property (access_i.wr_en && access_i.addr == 6'h2e && !$fell(sleep_i) |=>
    synth_ctrl_o.vco_select_cal_enable == $past(access_i.wdata[1])) else $error("select cal bit wrong");
  chk_wake_copy_b: assert property ($fell(sleep_i) |->
    ##[1:2] analog_test_b_int_o == (converter_keep_setting_i ? 8'h81 : 8'h88)) else $error("wake copy b wrong");
  chk_wake_copy_a: assert property ($fell(sleep_i) |->
    ##[1:2] analog_test_a_int_o == (converter_keep_setting_i ? 8'h35 : 8'h31)) else $error("wake copy a wrong");
endmodule

// >>> testbench/synth_cal_test_regs_test.sv
`timescale 1ns/100ps
module synth_cal_test_regs_test;
  import synth_cal_pkg::*;
  logic        sys_clk_i, rst_i, sleep_i, keep, rv, rvd;
  reg_access_t acc;
  cal_result_t cr;
  synth_ctrl_t ctl;
  logic [7:0]  rdata, tb_b, tb_a, lw;
  logic [7:0]  ex[$];
  int          bad_count, num_checks, cyc;
  logic [5:0]  ad[10] = '{6'h23, 6'h24, 6'h25, 6'h26, 6'h29, 6'h2a, 6'h2b, 6'h2c, 6'h2d, 6'h2e};
  logic [7:0]  rs[10] = '{8'ha9, 8'h0a, 8'h20, 8'h0d, 8'h59, 8'h7f, 8'h3f, 8'h88, 8'h31, 8'h0b};
  logic [7:0]  mk[10] = '{8'hff, 8'h3f, 8'h3f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  synth_cal_host u_host (.sys_clk_i, .access_o(acc));
  synth_cal_test_regs u_dut (.sys_clk_i, .rst_i, .access_i(acc), .cal_result_i(cr), .sleep_i,
    .converter_keep_setting_i(keep), .rdata_o(rdata), .synth_ctrl_o(ctl),
    .analog_test_b_int_o(tb_b), .analog_test_a_int_o(tb_a));
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic rd(logic [5:0] a, logic [7:0] e);
    u_host.put(1'b0, a, 8'h00);
    rv = 1'b1;
    ex.push_back(e);
  endtask
  task automatic wr(logic [5:0] a, logic [7:0] d);
    u_host.put(1'b1, a, d);
    rv = 1'b0;
  endtask
  task automatic nop(int n);
    repeat (n) begin
      u_host.put(1'b0, 6'h3f, 8'h00);
      rv = 1'b0;
    end
  endtask
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // Read data is valid for the cycle after its address was sampled
  always @(posedge sys_clk_i) rvd <= rv;
  always @(negedge sys_clk_i) if (rvd) chk("rdata", rdata, ex.pop_front());
  always @(posedge sys_clk_i) begin
    cyc += 1;
    if (cyc > 2000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    rst_i = 1'b1;
    sleep_i = 1'b0;
    keep = 1'b0;
    rv = 1'b0;
    cr = '0;
    void'($urandom(22122));
    repeat (12) @(negedge sys_clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 10; i++) rd(ad[i], rs[i]);
    rd(6'h27, 8'h00);
    for (int i = 0; i < 10; i++) wr(ad[i], 8'hff);
    for (int i = 0; i < 10; i++) rd(ad[i], mk[i]);
    for (int i = 0; i < 4; i++) begin
      wr(6'h23, {2'b00, 2'(i), 4'h9});
      nop(1);
      chk("pump_en", ctl.pump_cal_stage_enable, i != 0);
    end
    repeat (8) begin
      lw = 8'($urandom);
      wr(6'h24, lw);
      nop(1);
      chk("core_sel", ctl.vco_high_core_select, lw[5]);
      chk("vco_cur", ctl.vco_current, lw[4:0]);
    end
    @(negedge sys_clk_i) cr = {1'b1, 15'($urandom)};
    nop(1);
    cr.wr_en = 1'b0;
    chk("pump_cur", ctl.pump_current, cr.pump_current);
    chk("coarse", ctl.coarse_tune, cr.coarse_tune);
    rd(6'h23, {4'h3, cr.pump_current});
    rd(6'h24, {2'b00, lw[5], cr.vco_current});
    rd(6'h25, {2'b00, cr.coarse_tune});
    repeat (4) begin
      lw = 8'($urandom);
      wr(6'h26, lw);
      nop(1);
      chk("cal_ctrl", ctl.cal_control, lw & 8'h7f);
    end
    for (int k = 0; k < 2; k++) begin
      keep = k[0];
      for (int i = 4; i < 10; i++) wr(ad[i], 8'h00);
      sleep_i = 1'b1;
      nop(3);
      sleep_i = 1'b0;
      nop(3);
      chk("int_b", tb_b, k ? 8'h81 : 8'h88);
      chk("int_a", tb_a, k ? 8'h35 : 8'h31);
      chk("sel_cal", ctl.vco_select_cal_enable, 1'b1);
      rd(6'h2c, 8'h88);
      rd(6'h2d, 8'h31);
      rd(6'h29, 8'h59);
    end
    nop(3);
    end_sim();
  end
endmodule
bind synth_cal_test_regs synth_cal_sva u_sva (.sys_clk_i, .rst_i, .access_i, .cal_result_i, .sleep_i,
  .converter_keep_setting_i, .rdata_o, .synth_ctrl_o, .analog_test_b_int_o, .analog_test_a_int_o);

// >>> verilog/synth_cal_pkg.sv
package synth_cal_pkg;
  localparam logic [5:0] ADDR_CHARGE_PUMP_CAL     = 6'h23;
  localparam logic [5:0] ADDR_VCO_CURRENT_CAL     = 6'h24;
  localparam logic [5:0] ADDR_VCO_COARSE_TUNE_CAL = 6'h25;
  localparam logic [5:0] ADDR_SYNTH_CAL_CONTROL   = 6'h26;
  localparam logic [5:0] ADDR_RESERVED_TUNING_A   = 6'h29;
  localparam logic [5:0] ADDR_RESERVED_TUNING_B   = 6'h2a;
  localparam logic [5:0] ADDR_RESERVED_TUNING_C   = 6'h2b;
  localparam logic [5:0] ADDR_ANALOG_TEST_B       = 6'h2c;
  localparam logic [5:0] ADDR_ANALOG_TEST_A       = 6'h2d;
  localparam logic [5:0] ADDR_ANALOG_TEST_C       = 6'h2e;

  localparam logic [7:0] RST_CHARGE_PUMP_CAL      = 8'ha9;
  localparam logic [7:0] RST_VCO_CURRENT_CAL      = 8'h0a;
  localparam logic [7:0] RST_VCO_COARSE_TUNE_CAL  = 8'h20;
  localparam logic [7:0] RST_SYNTH_CAL_CONTROL    = 8'h0d;
  localparam logic [7:0] RST_RESERVED_TUNING_A    = 8'h59;
  localparam logic [7:0] RST_RESERVED_TUNING_B    = 8'h7f;
  localparam logic [7:0] RST_RESERVED_TUNING_C    = 8'h3f;
  localparam logic [7:0] RST_ANALOG_TEST_B        = 8'h88;
  localparam logic [7:0] RST_ANALOG_TEST_A        = 8'h31;
  localparam logic [7:0] RST_ANALOG_TEST_C        = 8'h0b;

  localparam logic [7:0] WAKE_TEST_B_KEEP         = 8'h81;
  localparam logic [7:0] WAKE_TEST_A_KEEP         = 8'h35;

  localparam logic [7:0] MASK_CHARGE_PUMP_CAL     = 8'hff;
  localparam logic [7:0] MASK_VCO_CURRENT_CAL     = 8'h3f;
  localparam logic [7:0] MASK_VCO_COARSE_TUNE_CAL = 8'h3f;
  localparam logic [7:0] MASK_SYNTH_CAL_CONTROL   = 8'h7f;

  localparam int PUMP_EN_LSB    = 4;
  localparam int PUMP_EN_MSB    = 5;
  localparam int PUMP_CUR_MSB   = 3;
  localparam int CORE_SEL_BIT   = 5;
  localparam int VCO_CUR_MSB    = 4;
  localparam int COARSE_MSB     = 5;
  localparam int CTRL_MSB       = 6;
  localparam int SEL_CAL_EN_BIT = 1;

  typedef struct packed {
    logic       wr_en;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_access_t;

  typedef struct packed {
    logic       pump_cal_stage_enable;
    logic [3:0] pump_current;
    logic       vco_high_core_select;
    logic [4:0] vco_current;
    logic [5:0] coarse_tune;
    logic [6:0] cal_control;
    logic       vco_select_cal_enable;
  } synth_ctrl_t;

  typedef struct packed {
    logic       wr_en;
    logic [3:0] pump_current;
    logic [4:0] vco_current;
    logic [5:0] coarse_tune;
  } cal_result_t;
endpackage

// >>> verilog/synth_cal_test_regs.sv
`timescale 1ns/100ps
module synth_cal_test_regs (
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  input  wire synth_cal_pkg::reg_access_t  access_i,
  input  wire synth_cal_pkg::cal_result_t  cal_result_i,
  input  wire logic                        sleep_i,
  input  wire logic                        converter_keep_setting_i,
  output logic [7:0]                       rdata_o,
  output synth_cal_pkg::synth_ctrl_t       synth_ctrl_o,
  output logic [7:0]                       analog_test_b_int_o,
  output logic [7:0]                       analog_test_a_int_o
);
  import synth_cal_pkg::*;

  logic [7:0]  charge_pump_cal_r;
  logic [7:0]  charge_pump_cal_nxt;
  logic [7:0]  vco_current_cal_r;
  logic [7:0]  vco_current_cal_nxt;
  logic [7:0]  vco_coarse_tune_cal_r;
  logic [7:0]  vco_coarse_tune_cal_nxt;
  logic [7:0]  synth_cal_control_r;
  logic [7:0]  synth_cal_control_nxt;
  logic [7:0]  reserved_tuning_a_r;
  logic [7:0]  reserved_tuning_a_nxt;
  logic [7:0]  reserved_tuning_b_r;
  logic [7:0]  reserved_tuning_b_nxt;
  logic [7:0]  reserved_tuning_c_r;
  logic [7:0]  reserved_tuning_c_nxt;
  logic [7:0]  analog_test_b_r;
  logic [7:0]  analog_test_b_nxt;
  logic [7:0]  analog_test_a_r;
  logic [7:0]  analog_test_a_nxt;
  logic [7:0]  analog_test_c_r;
  logic [7:0]  analog_test_c_nxt;
  logic [7:0]  test_b_int_r;
  logic [7:0]  test_b_int_nxt;
  logic [7:0]  test_a_int_r;
  logic [7:0]  test_a_int_nxt;
  logic        sleep_r;
  logic        sleep_nxt;
  logic        wake;
  logic [7:0]  rdata_nxt;
  synth_ctrl_t ctrl_r;
  synth_ctrl_t ctrl_nxt;

  // Register write strobe for one address
  function automatic logic hit(input reg_access_t acc, input logic [5:0] a);
    hit = acc.wr_en && (acc.addr == a);
  endfunction

  // Next value of a register whose contents do not survive sleep
  function automatic logic [7:0] volatile_next(input logic [7:0]  cur,
                                               input reg_access_t acc,
                                               input logic [5:0]  a,
                                               input logic        wake_now,
                                               input logic [7:0]  wake_val);
    volatile_next = cur;
    if (hit(acc, a)) begin
      volatile_next = acc.wdata;
    end
    if (wake_now) begin
      volatile_next = wake_val;
    end
  endfunction

  // Sleep tracking: a falling sleep level is the wake event
  always_comb begin
    sleep_nxt = sleep_i;
    wake      = sleep_r && !sleep_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sleep_r <= 1'b0;
    end else begin
      sleep_r <= sleep_nxt;
    end
  end

  // Software writes win over the calibration engine
  always_comb begin
    charge_pump_cal_nxt = charge_pump_cal_r;
    if (cal_result_i.wr_en) begin
      charge_pump_cal_nxt[PUMP_CUR_MSB:0] = cal_result_i.pump_current;
    end
    if (hit(access_i, ADDR_CHARGE_PUMP_CAL)) begin
      charge_pump_cal_nxt = access_i.wdata & MASK_CHARGE_PUMP_CAL;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      charge_pump_cal_r <= RST_CHARGE_PUMP_CAL;
    end else begin
      charge_pump_cal_r <= charge_pump_cal_nxt;
    end
  end

  // VCO current result with software override
  always_comb begin
    vco_current_cal_nxt = vco_current_cal_r;
    if (cal_result_i.wr_en) begin
      vco_current_cal_nxt[VCO_CUR_MSB:0] = cal_result_i.vco_current;
    end
    if (hit(access_i, ADDR_VCO_CURRENT_CAL)) begin
      vco_current_cal_nxt = access_i.wdata & MASK_VCO_CURRENT_CAL;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      vco_current_cal_r <= RST_VCO_CURRENT_CAL;
    end else begin
      vco_current_cal_r <= vco_current_cal_nxt;
    end
  end

  // Coarse tuning capacitor setting
  always_comb begin
    vco_coarse_tune_cal_nxt = vco_coarse_tune_cal_r;
    if (cal_result_i.wr_en) begin
      vco_coarse_tune_cal_nxt[COARSE_MSB:0] = cal_result_i.coarse_tune;
    end
    if (hit(access_i, ADDR_VCO_COARSE_TUNE_CAL)) begin
      vco_coarse_tune_cal_nxt = access_i.wdata & MASK_VCO_COARSE_TUNE_CAL;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      vco_coarse_tune_cal_r <= RST_VCO_COARSE_TUNE_CAL;
    end else begin
      vco_coarse_tune_cal_r <= vco_coarse_tune_cal_nxt;
    end
  end

  // Calibration control, software only
  always_comb begin
    synth_cal_control_nxt = synth_cal_control_r;
    if (hit(access_i, ADDR_SYNTH_CAL_CONTROL)) begin
      synth_cal_control_nxt = access_i.wdata & MASK_SYNTH_CAL_CONTROL;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      synth_cal_control_r <= RST_SYNTH_CAL_CONTROL;
    end else begin
      synth_cal_control_r <= synth_cal_control_nxt;
    end
  end

  // Sleep-volatile bank comes back at reset values; wake beats a same-cycle write
  always_comb begin
    reserved_tuning_a_nxt = volatile_next(reserved_tuning_a_r, access_i, ADDR_RESERVED_TUNING_A,
                                          wake, RST_RESERVED_TUNING_A);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reserved_tuning_a_r <= RST_RESERVED_TUNING_A;
    end else begin
      reserved_tuning_a_r <= reserved_tuning_a_nxt;
    end
  end

  always_comb begin
    reserved_tuning_b_nxt = volatile_next(reserved_tuning_b_r, access_i, ADDR_RESERVED_TUNING_B,
                                          wake, RST_RESERVED_TUNING_B);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reserved_tuning_b_r <= RST_RESERVED_TUNING_B;
    end else begin
      reserved_tuning_b_r <= reserved_tuning_b_nxt;
    end
  end

  always_comb begin
    reserved_tuning_c_nxt = volatile_next(reserved_tuning_c_r, access_i, ADDR_RESERVED_TUNING_C,
                                          wake, RST_RESERVED_TUNING_C);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      reserved_tuning_c_r <= RST_RESERVED_TUNING_C;
    end else begin
      reserved_tuning_c_r <= reserved_tuning_c_nxt;
    end
  end

  always_comb begin
    analog_test_b_nxt = volatile_next(analog_test_b_r, access_i, ADDR_ANALOG_TEST_B,
                                      wake, RST_ANALOG_TEST_B);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      analog_test_b_r <= RST_ANALOG_TEST_B;
    end else begin
      analog_test_b_r <= analog_test_b_nxt;
    end
  end

  always_comb begin
    analog_test_a_nxt = volatile_next(analog_test_a_r, access_i, ADDR_ANALOG_TEST_A,
                                      wake, RST_ANALOG_TEST_A);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      analog_test_a_r <= RST_ANALOG_TEST_A;
    end else begin
      analog_test_a_r <= analog_test_a_nxt;
    end
  end

  always_comb begin
    analog_test_c_nxt = volatile_next(analog_test_c_r, access_i, ADDR_ANALOG_TEST_C,
                                      wake, RST_ANALOG_TEST_C);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      analog_test_c_r <= RST_ANALOG_TEST_C;
    end else begin
      analog_test_c_r <= analog_test_c_nxt;
    end
  end

  // Internal analog copies: retention inversion never shows on the read path
  always_comb begin
    test_b_int_nxt = test_b_int_r;
    if (hit(access_i, ADDR_ANALOG_TEST_B)) begin
      test_b_int_nxt = access_i.wdata;
    end
    if (wake) begin
      test_b_int_nxt = converter_keep_setting_i ? WAKE_TEST_B_KEEP : RST_ANALOG_TEST_B;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      test_b_int_r <= RST_ANALOG_TEST_B;
    end else begin
      test_b_int_r <= test_b_int_nxt;
    end
  end

  always_comb begin
    test_a_int_nxt = test_a_int_r;
    if (hit(access_i, ADDR_ANALOG_TEST_A)) begin
      test_a_int_nxt = access_i.wdata;
    end
    if (wake) begin
      test_a_int_nxt = converter_keep_setting_i ? WAKE_TEST_A_KEEP : RST_ANALOG_TEST_A;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      test_a_int_r <= RST_ANALOG_TEST_A;
    end else begin
      test_a_int_r <= test_a_int_nxt;
    end
  end

  // Read path shows the stored value, not a same-cycle write
  always_comb begin
    unique case (access_i.addr)
      ADDR_CHARGE_PUMP_CAL:     rdata_nxt = charge_pump_cal_r;
      ADDR_VCO_CURRENT_CAL:     rdata_nxt = vco_current_cal_r;
      ADDR_VCO_COARSE_TUNE_CAL: rdata_nxt = vco_coarse_tune_cal_r;
      ADDR_SYNTH_CAL_CONTROL:   rdata_nxt = synth_cal_control_r;
      ADDR_RESERVED_TUNING_A:   rdata_nxt = reserved_tuning_a_r;
      ADDR_RESERVED_TUNING_B:   rdata_nxt = reserved_tuning_b_r;
      ADDR_RESERVED_TUNING_C:   rdata_nxt = reserved_tuning_c_r;
      ADDR_ANALOG_TEST_B:       rdata_nxt = analog_test_b_r;
      ADDR_ANALOG_TEST_A:       rdata_nxt = analog_test_a_r;
      ADDR_ANALOG_TEST_C:       rdata_nxt = analog_test_c_r;
      default:                  rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_nxt;
    end
  end

  // Control fields are taken from the next-state values, so they change on the same edge as the registers, except that reset clears them to zero
  always_comb begin
    ctrl_nxt.pump_cal_stage_enable = |charge_pump_cal_nxt[PUMP_EN_MSB:PUMP_EN_LSB];
    ctrl_nxt.pump_current          = charge_pump_cal_nxt[PUMP_CUR_MSB:0];
    ctrl_nxt.vco_high_core_select  = vco_current_cal_nxt[CORE_SEL_BIT];
    ctrl_nxt.vco_current           = vco_current_cal_nxt[VCO_CUR_MSB:0];
    ctrl_nxt.coarse_tune           = vco_coarse_tune_cal_nxt[COARSE_MSB:0];
    ctrl_nxt.cal_control           = synth_cal_control_nxt[CTRL_MSB:0];
    ctrl_nxt.vco_select_cal_enable = analog_test_c_nxt[SEL_CAL_EN_BIT];
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign synth_ctrl_o        = ctrl_r;
  assign analog_test_b_int_o = test_b_int_r;
  assign analog_test_a_int_o = test_a_int_r;
endmodule
